// [rtl/sma_pkg.sv]
// shared constants and carriers for the static memory access control block
package sma_pkg;

	// width of every decoded setup, pulse and cycle length
	localparam int unsigned SMA_LEN_W = 9;
	// width of the float wait count field
	localparam int unsigned SMA_FLOAT_W = 4;
	// number of byte lanes on the widest bus
	localparam int unsigned SMA_LANES = 4;
	// synchroniser depth for the pin input and the reset release
	localparam int unsigned SMA_SYNC_DEPTH = 2;

	// wait handling mode codes
	localparam logic [1:0] SMA_WAIT_DISABLED = 2'h0;
	localparam logic [1:0] SMA_WAIT_RESERVED = 2'h1;
	localparam logic [1:0] SMA_WAIT_FROZEN   = 2'h2;
	localparam logic [1:0] SMA_WAIT_READY    = 2'h3;

	// bus width codes
	localparam logic [1:0] SMA_BW_8        = 2'h0;
	localparam logic [1:0] SMA_BW_16       = 2'h1;
	localparam logic [1:0] SMA_BW_32       = 2'h2;
	localparam logic [1:0] SMA_BW_RESERVED = 2'h3;

	// lane masks that each bus width allows
	localparam logic [3:0] SMA_MASK_8  = 4'h1;
	localparam logic [3:0] SMA_MASK_16 = 4'h3;
	localparam logic [3:0] SMA_MASK_32 = 4'hf;

	// values after reset
	localparam logic [8:0] SMA_CNT_RST   = 9'h000;
	localparam logic [4:0] SMA_FLOAT_RST = 5'h00;
	localparam logic       SMA_STB_RST   = 1'b1;
	localparam logic [3:0] SMA_LANE_RST  = 4'hf;
	localparam logic [1:0] SMA_RST_SYNC  = 2'h0;
	localparam logic [1:0] SMA_WAIT_SYNC = 2'h3;

	// timing of one access direction, already decoded to cycles
	typedef struct packed {
		logic [8:0] cs_setup;
		logic [8:0] cs_pulse;
		logic [8:0] st_setup;
		logic [8:0] st_pulse;
		logic [8:0] cycle;
	} sma_timing_t;

	// per chip select mode configuration
	typedef struct packed {
		logic       byte_lane_style;
		logic [1:0] wait_handling_mode;
		logic       float_overlap_enable;
		logic [3:0] float_wait_count;
		logic [1:0] bus_width_code;
		logic       read_ctrl_sel;
		logic       write_ctrl_sel;
	} sma_cfg_t;

	// strobes as they leave the block
	typedef struct packed {
		logic       select_strobe_n;
		logic       read_strobe_n;
		logic       write_strobe_n;
		logic [3:0] byte_write_strobe_n;
		logic [3:0] byte_lane_select_n;
	} sma_pins_t;

	// engine states
	typedef enum logic [0:0] {
		SMA_IDLE,
		SMA_RUN
	} sma_state_t;

endpackage

// [rtl/sma_sync.sv]
// two flip-flop synchroniser for levels entering the clock domain
module sma_sync
	import sma_pkg::*;
#(
	parameter int unsigned     WIDTH     = 1,
	parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_reg;

	initial begin
		if (WIDTH < 1) begin
			$error("sma_sync width must be at least one");
		end
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= RST_VALUE;
			dout     <= RST_VALUE;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end

endmodule

// [rtl/sma_phase.sv]
// decodes one strobe's setup and pulse window from the cycle counter
module sma_phase
	import sma_pkg::*;
#(
	parameter int unsigned LEN_W = SMA_LEN_W
) (
	input  wire logic [LEN_W-1:0] count,
	input  wire logic [LEN_W-1:0] setup,
	input  wire logic [LEN_W-1:0] pulse,
	output logic                  active,
	output logic                  last,
	output logic                  in_setup
);

	logic [LEN_W:0] pulse_end;

	// one extra bit keeps setup plus pulse from wrapping
	assign pulse_end = {1'b0, setup} + {1'b0, pulse};
	assign in_setup  = {1'b0, count} < {1'b0, setup};
	assign active    = !in_setup && ({1'b0, count} < pulse_end);
	assign last      = active && (({1'b0, count} + {{LEN_W{1'b0}}, 1'b1}) == pulse_end);

endmodule

// [rtl/sma_access.sv]
// access engine of one static memory chip select: strobes, wait input, float time
// What this block does
// - lane style only matters on 16/32-bit bus
// - style 1: per-byte write strobes, plain reads
// - style 0: write strobe plus byte lane selects
// - wait input sampled only in controlling pulse
// - wait mode codes; disabled ignores wait input
// - frozen mode halts cycle, resumes same point
// - ready mode extends pulse end while low
// - write selector 1: write strobe controls writes
// - write selector 0: select strobe controls writes
// - read selector 1: read strobe, busy after rise
// - read selector 1: float follows read strobe rise
// - read selector 0: select strobe controls reads
// - float period plus one turnaround cycle busy
// - bus width codes 8, 16, 32, reserved
// - overlap float with next setup when enabled
module sma_access
	import sma_pkg::*;
#(
	parameter int unsigned LEN_W = SMA_LEN_W
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire sma_cfg_t    cfg,
	input  wire sma_timing_t rd_timing,
	input  wire sma_timing_t wr_timing,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [3:0]  req_byte_en,
	output logic             req_ready,
	output logic             access_done,
	output logic             access_frozen,
	output logic             bus_busy,
	output logic             select_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             byte0_write_strobe_n,
	output logic             byte1_write_strobe_n,
	output logic             byte2_write_strobe_n,
	output logic             byte3_write_strobe_n,
	output logic             byte0_lane_select_n,
	output logic             byte1_lane_select_n,
	output logic             byte2_lane_select_n,
	output logic             byte3_lane_select_n,
	input  wire logic        external_wait_n
);

	initial begin
		if (LEN_W != SMA_LEN_W) begin
			$error("sma_access length width must match the timing carrier");
		end
	end

	// lane mask for a bus width code, the reserved code acts as 8-bit
	function automatic logic [3:0] lane_mask(input logic [1:0] code);
		case (code)
			SMA_BW_16: lane_mask = SMA_MASK_16;
			SMA_BW_32: lane_mask = SMA_MASK_32;
			default:   lane_mask = SMA_MASK_8;
		endcase
	endfunction

	logic             rst_sync_n;
	logic             wait_n_sync;
	sma_state_t       state_reg;
	sma_state_t       state_next;
	logic [LEN_W-1:0] count_reg;
	logic [LEN_W-1:0] count_next;
	logic             write_reg;
	logic [3:0]       byte_en_reg;
	logic [4:0]       float_reg;
	logic [4:0]       float_next;
	sma_pins_t        pins_reg;
	sma_pins_t        pins_next;
	logic             done_reg;
	logic             frozen_reg;

	// reset release passes two flip-flops
	sma_sync #(
		.WIDTH     (1),
		.RST_VALUE (1'b0)
	) u_rst_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  (1'b1),
		.dout (rst_sync_n)
	);

	// wait pin is asynchronous to clk
	sma_sync #(
		.WIDTH     (1),
		.RST_VALUE (1'b1)
	) u_wait_sync (
		.clk  (clk),
		.rstn (rst_sync_n),
		.din  (external_wait_n),
		.dout (wait_n_sync)
	);

	// timing of the access in flight and of a request waiting to start
	sma_timing_t tim_cur;
	sma_timing_t tim_req;
	assign tim_cur = write_reg ? wr_timing : rd_timing;
	assign tim_req = req_write ? wr_timing : rd_timing;

	// phase windows of the two timed strobes, select and read/write
	logic cs_active, cs_last, cs_setup;
	logic st_active, st_last, st_setup;

	sma_phase #(
		.LEN_W (LEN_W)
	) u_cs_phase (
		.count    (count_reg),
		.setup    (tim_cur.cs_setup),
		.pulse    (tim_cur.cs_pulse),
		.active   (cs_active),
		.last     (cs_last),
		.in_setup (cs_setup)
	);

	sma_phase #(
		.LEN_W (LEN_W)
	) u_st_phase (
		.count    (count_reg),
		.setup    (tim_cur.st_setup),
		.pulse    (tim_cur.st_pulse),
		.active   (st_active),
		.last     (st_last),
		.in_setup (st_setup)
	);

	// controlling strobe selection per direction
	wire ctrl_sel    = write_reg ? cfg.write_ctrl_sel : cfg.read_ctrl_sel;
	wire ctrl_active = ctrl_sel ? st_active : cs_active;
	wire ctrl_last   = ctrl_sel ? st_last : cs_last;
	wire running     = (state_reg == SMA_RUN);

	// wait input is looked at only inside the controlling pulse
	wire wait_seen   = running && ctrl_active && !wait_n_sync;
	wire mode_frozen = (cfg.wait_handling_mode == SMA_WAIT_FROZEN);
	wire mode_ready  = (cfg.wait_handling_mode == SMA_WAIT_READY);
	wire freeze      = mode_frozen && wait_seen;
	// ready mode only checks on the last pulse cycle, so the pulse stretches
	wire stretch     = mode_ready && wait_seen && ctrl_last;
	wire hold_count  = freeze || stretch;

	// end of access; a zero cycle length still takes one cycle
	wire [LEN_W-1:0] last_count = (tim_cur.cycle == '0) ? '0 : tim_cur.cycle - 1'b1;
	wire cycle_end  = running && !hold_count && (count_reg >= last_count);

	// a read's controlling strobe rises after its last pulse cycle
	wire read_rise  = running && !write_reg && ctrl_last && !hold_count;

	// start condition: wait out the float time, or hide it in the next setup
	wire req_ctrl_sel      = req_write ? cfg.write_ctrl_sel : cfg.read_ctrl_sel;
	wire [LEN_W-1:0] req_setup = req_ctrl_sel ? tim_req.st_setup : tim_req.cs_setup;
	wire float_clear       = (float_reg == '0);
	wire float_hidden      = cfg.float_overlap_enable &&
				 ({{(LEN_W-5){1'b0}}, float_reg} <= req_setup);
	wire start_ok          = !running && (float_clear || float_hidden);
	wire start             = req_valid && start_ok;

	assign req_ready = start_ok;

	// engine state and counter
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		if (start) begin
			state_next = SMA_RUN;
			count_next = '0;
		end else if (cycle_end) begin
			state_next = SMA_IDLE;
			count_next = '0;
		end else if (running && !hold_count) begin
			count_next = count_reg + 1'b1;
		end
	end

	// float period plus one turnaround cycle; a new read rise reloads it
	always_comb begin
		float_next = float_reg;
		if (read_rise) begin
			float_next = {1'b0, cfg.float_wait_count} + 5'h01;
		end else if (!float_clear) begin
			float_next = float_reg - 5'h01;
		end
	end

	// byte lanes that the bus width lets through
	wire [3:0] lanes    = byte_en_reg & lane_mask(cfg.bus_width_code);
	// the lane style only exists on a 16 or 32-bit bus
	wire       wide_bus = (cfg.bus_width_code == SMA_BW_16) ||
			      (cfg.bus_width_code == SMA_BW_32);
	wire       style_wr = wide_bus && cfg.byte_lane_style;
	wire       rd_pulse = running && !write_reg && st_active;
	wire       wr_pulse = running && write_reg && st_active;
	wire       cs_pulse = running && cs_active;

	// next pin levels; frozen counter keeps them steady by construction
	always_comb begin
		pins_next = '{
			select_strobe_n:     SMA_STB_RST,
			read_strobe_n:       SMA_STB_RST,
			write_strobe_n:      SMA_STB_RST,
			byte_write_strobe_n: SMA_LANE_RST,
			byte_lane_select_n:  SMA_LANE_RST
		};
		pins_next.select_strobe_n = !cs_pulse;
		pins_next.read_strobe_n   = !rd_pulse;
		if (style_wr) begin
			pins_next.byte_write_strobe_n = ~({4{wr_pulse}} & lanes);
		end else begin
			pins_next.write_strobe_n = !wr_pulse;
		end
		// lane selects belong to style 0 only, reads of style 1 leave them idle
		if (wide_bus && !cfg.byte_lane_style) begin
			pins_next.byte_lane_select_n = ~({4{cs_pulse}} & lanes);
		end
	end

	// registered state; the counter simply does not move while frozen
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= SMA_IDLE;
			count_reg <= SMA_CNT_RST;
			float_reg <= SMA_FLOAT_RST;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			float_reg <= float_next;
		end
	end

	// request fields are captured at start and kept for the whole access
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			write_reg   <= 1'b0;
			byte_en_reg <= 4'h0;
		end else if (start) begin
			write_reg   <= req_write;
			byte_en_reg <= req_byte_en;
		end
	end

	// pins and status leave from flip-flops, one cycle after the counter
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pins_reg   <= '{
				select_strobe_n:     SMA_STB_RST,
				read_strobe_n:       SMA_STB_RST,
				write_strobe_n:      SMA_STB_RST,
				byte_write_strobe_n: SMA_LANE_RST,
				byte_lane_select_n:  SMA_LANE_RST
			};
			done_reg   <= 1'b0;
			frozen_reg <= 1'b0;
		end else begin
			pins_reg   <= pins_next;
			done_reg   <= cycle_end;
			frozen_reg <= freeze;
		end
	end

	// status outputs
	assign access_done   = done_reg;
	assign access_frozen = frozen_reg;
	assign bus_busy      = !float_clear;

	// pin outputs
	assign select_strobe_n      = pins_reg.select_strobe_n;
	assign read_strobe_n        = pins_reg.read_strobe_n;
	assign write_strobe_n       = pins_reg.write_strobe_n;
	assign byte0_write_strobe_n = pins_reg.byte_write_strobe_n[0];
	assign byte1_write_strobe_n = pins_reg.byte_write_strobe_n[1];
	assign byte2_write_strobe_n = pins_reg.byte_write_strobe_n[2];
	assign byte3_write_strobe_n = pins_reg.byte_write_strobe_n[3];
	assign byte0_lane_select_n  = pins_reg.byte_lane_select_n[0];
	assign byte1_lane_select_n  = pins_reg.byte_lane_select_n[1];
	assign byte2_lane_select_n  = pins_reg.byte_lane_select_n[2];
	assign byte3_lane_select_n  = pins_reg.byte_lane_select_n[3];

endmodule

// [testbench/sma_access_properties.sv]
// concurrent checks on the access engine ports
module sma_access_properties
	import sma_pkg::*;
#(
	parameter int unsigned LEN_W = SMA_LEN_W
) (
	input  wire logic     clk,
	input  wire logic     rstn,
	input  wire sma_cfg_t cfg,
	input  wire logic     req_ready,
	input  wire logic     access_frozen,
	input  wire logic     bus_busy,
	input  wire logic     select_strobe_n,
	input  wire logic     read_strobe_n,
	input  wire logic     write_strobe_n,
	input  wire logic     byte0_write_strobe_n,
	input  wire logic     byte3_write_strobe_n,
	input  wire logic     byte0_lane_select_n,
	input  wire logic     byte3_lane_select_n
);
	logic       wide;
	logic [4:0] busy_run_reg;
	logic       bw_idle;
	logic       ln_idle;
	// only 16 and 32 bit buses carry byte lanes
	assign wide = (cfg.bus_width_code == SMA_BW_16) || (cfg.bus_width_code == SMA_BW_32);
	assign bw_idle = byte0_write_strobe_n && byte3_write_strobe_n;
	assign ln_idle = byte0_lane_select_n && byte3_lane_select_n;
	// length of the busy stretch; 5 bits so float plus turnaround overflow shows
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_run_reg <= 5'h00;
		end else begin
			busy_run_reg <= bus_busy ? busy_run_reg + 5'h01 : 5'h00;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_busy_blocks_start: assert property (
		bus_busy && !cfg.float_overlap_enable |-> !req_ready) else $error("start while busy");
	a_busy_max_len: assert property (busy_run_reg <= 5'h10) else $error("busy too long");
	a_style1_idle: assert property (
		$past(wide && cfg.byte_lane_style) |-> write_strobe_n && ln_idle) else $error("style1 pins");
	a_narrow_idle: assert property ($past(!wide) |-> bw_idle && ln_idle) else $error("narrow");
	a_style0_bytewr: assert property ($past(!cfg.byte_lane_style) |-> bw_idle) else $error("s0");
	a_read_no_write: assert property (
		!read_strobe_n |-> write_strobe_n && bw_idle) else $error("read with write strobe");
	a_freeze_needs_mode: assert property (
		access_frozen |-> $past(cfg.wait_handling_mode) == SMA_WAIT_FROZEN) else $error("freeze mode");
	a_freeze_holds_pins: assert property (access_frozen |=>
		$stable({select_strobe_n, read_strobe_n, write_strobe_n})) else $error("pins moved in freeze");
	c_frozen: cover property (access_frozen);
	c_busy_end: cover property (bus_busy ##1 !bus_busy);
	c_byte_write: cover property ($fell(byte0_write_strobe_n));
	c_lane_select: cover property ($fell(byte3_lane_select_n));
endmodule

bind sma_access sma_access_properties #(.LEN_W(LEN_W)) chk_u (.clk(clk), .rstn(rstn), .cfg(cfg),
	.req_ready(req_ready), .access_frozen(access_frozen), .bus_busy(bus_busy),
	.select_strobe_n(select_strobe_n), .read_strobe_n(read_strobe_n),
	.write_strobe_n(write_strobe_n), .byte0_write_strobe_n(byte0_write_strobe_n),
	.byte3_write_strobe_n(byte3_write_strobe_n), .byte0_lane_select_n(byte0_lane_select_n),
	.byte3_lane_select_n(byte3_lane_select_n));

// [testbench/sma_mem_model.sv]
// slow external memory that holds its wait line low for a set time
module sma_mem_model
	import sma_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       select_strobe_n,
	input  wire logic [3:0] hold_cycles,
	output logic            external_wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_reg;
	// not ready from before selection until hold_cycles after it
	always @(posedge clk) begin
		if (select_strobe_n) begin
			left_reg <= hold_cycles;
		end else if (left_reg != 4'h0) begin
			left_reg <= left_reg - 4'h1;
		end
	end
	assign external_wait_n = (left_reg == 4'h0); // high once it can finish
endmodule

// [testbench/sma_access_tb.sv]
// self-checking bench for the access engine against a behavioural model
module sma_access_tb
	import sma_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rstn;
	sma_cfg_t    cfg;
	sma_timing_t rd_t;
	sma_timing_t wr_t;
	logic        req_valid;
	logic        req_write;
	logic [3:0]  req_byte_en;
	logic [3:0]  hold;
	logic        req_ready;
	logic        access_done;
	logic        bus_busy;
	logic        wait_n;
	wire sma_pins_t pins;
	int          fails = 0;
	int          checks = 0;
	int          cyc = 0;

	sma_access dut_u (.clk(clk), .rstn(rstn), .cfg(cfg), .rd_timing(rd_t), .wr_timing(wr_t),
		.req_valid(req_valid), .req_write(req_write), .req_byte_en(req_byte_en),
		.req_ready(req_ready), .access_done(access_done), .access_frozen(), .bus_busy(bus_busy),
		.select_strobe_n(pins.select_strobe_n), .read_strobe_n(pins.read_strobe_n),
		.write_strobe_n(pins.write_strobe_n),
		.byte0_write_strobe_n(pins.byte_write_strobe_n[0]),
		.byte1_write_strobe_n(pins.byte_write_strobe_n[1]),
		.byte2_write_strobe_n(pins.byte_write_strobe_n[2]),
		.byte3_write_strobe_n(pins.byte_write_strobe_n[3]),
		.byte0_lane_select_n(pins.byte_lane_select_n[0]),
		.byte1_lane_select_n(pins.byte_lane_select_n[1]),
		.byte2_lane_select_n(pins.byte_lane_select_n[2]),
		.byte3_lane_select_n(pins.byte_lane_select_n[3]), .external_wait_n(wait_n));

	sma_mem_model mem_u (.clk(clk), .select_strobe_n(pins.select_strobe_n),
		.hold_cycles(hold), .external_wait_n(wait_n));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// hang guard; a full run needs a few thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic sma_timing_t timing();
		sma_timing_t t;
		t.cs_setup = 9'($urandom_range(2));
		t.cs_pulse = 9'($urandom_range(3, 1));
		t.st_setup = 9'($urandom_range(2));
		t.st_pulse = 9'($urandom_range(3, 1));
		t.cycle = 9'(6 + $urandom_range(1)); // always leaves a hold cycle
		return t;
	endfunction

	// one access, sampled every cycle until done and the bus is free
	task automatic run(input logic wr);
		int n, sel, rd, wl, busy, first, lat, norm, ctl;
		logic [3:0] bw, ln, mask;
		logic wide, stall;
		sma_timing_t t;
		n = 0; sel = 0; rd = 0; wl = 0; busy = 0; first = 0; lat = 0; bw = 4'h0; ln = 4'h0;
		t = wr ? wr_t : rd_t;
		wide = cfg.bus_width_code inside {SMA_BW_16, SMA_BW_32};
		mask = (cfg.bus_width_code == SMA_BW_32) ? SMA_MASK_32 :
			(cfg.bus_width_code == SMA_BW_16) ? SMA_MASK_16 : SMA_MASK_8;
		stall = (hold != 4'h0) && cfg.wait_handling_mode[1];
		norm = ((t.cycle > 0) ? int'(t.cycle) : 1) + 1;
		ctl = cfg.read_ctrl_sel ? int'(t.st_setup + t.st_pulse) : int'(t.cs_setup + t.cs_pulse);
		req_write = wr;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		do begin
			n++;
			sel += !pins.select_strobe_n;
			rd += !pins.read_strobe_n;
			wl += !pins.write_strobe_n;
			bw |= ~pins.byte_write_strobe_n;
			ln |= ~pins.byte_lane_select_n;
			busy += bus_busy;
			if (bus_busy === 1'b1 && first == 0) first = n;
			if (access_done === 1'b1) lat = n;
			@(negedge clk);
		end while ((lat == 0 || bus_busy !== 1'b0) && n < 200);
		if (stall) begin
			cmp(8'(lat > norm && lat <= norm + hold + 5), 8'h01);
		end else begin
			cmp(8'(lat), 8'(norm));
			cmp(8'(sel), 8'(t.cs_pulse));
			cmp(8'(rd), wr ? 8'h00 : 8'(t.st_pulse));
			cmp(8'(wl), (wr && !(wide && cfg.byte_lane_style)) ? 8'(t.st_pulse) : 8'h00);
			cmp(8'(first), wr ? 8'h00 : 8'(ctl + 1));
		end
		cmp(8'(bw), (wr && wide && cfg.byte_lane_style) ? 8'(req_byte_en & mask) : 8'h00);
		cmp(8'(ln), (wide && !cfg.byte_lane_style) ? 8'(req_byte_en & mask) : 8'h00);
		cmp(8'(busy), wr ? 8'h00 : 8'(cfg.float_wait_count + 1));
	endtask

	// random configurations, every other access against a stalling memory
	initial begin
		rstn = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_byte_en = 4'h0;
		hold = 4'h0;
		cfg = '0;
		rd_t = '0;
		wr_t = '0;
		void'($urandom(89));
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 120; i++) begin
			cfg = sma_cfg_t'($urandom);
			rd_t = timing();
			wr_t = timing();
			req_byte_en = 4'($urandom_range(15, 1));
			hold = i[0] ? 4'hc : 4'h0;
			// the memory only counts while selected, so select covers the strobe pulse
			if (i[0]) begin
				rd_t.cs_setup = 9'h000;
				rd_t.cs_pulse = rd_t.st_setup + rd_t.st_pulse;
				wr_t.cs_setup = 9'h000;
				wr_t.cs_pulse = wr_t.st_setup + wr_t.st_pulse;
			end
			// let a changed wait level pass the synchroniser before the request
			repeat (3) @(negedge clk);
			run(1'($urandom));
		end
		conclude();
	end
endmodule
